// ---- core/fba_cfg.svh ----
// Constants for the dual block nonvolatile array access logic.
// Assumes a single bus clock; included by the top module only.
`ifndef FBA_CFG_SVH
`define FBA_CFG_SVH
`define FBA_BLOCKS      2
`define FBA_ROWS        1024
`define FBA_ROW_BYTES   64
`define FBA_SECT_ROWS   8
`define FBA_ERASED_WORD 16'hFFFF
`define FBA_CMD_WIN_LO  16'h0100
`define FBA_CMD_WIN_HI  16'h010F
`define FBA_OP_PROG     2'h1
`define FBA_OP_SECT     2'h2
`define FBA_OP_MASS     2'h3
`endif

// ---- core/fba_pkg.sv ----
// Types shared by the array access logic.
// Assumes nothing beyond the configuration header.
`default_nettype none
package fba_pkg;
  typedef enum logic [1:0] {BLK_IDLE, BLK_PROG, BLK_ERASE} fba_blk_st_t;
  typedef enum logic {RD_IDLE, RD_SECOND} fba_rd_st_t;
endpackage
`default_nettype wire

// ---- core/fba_top.sv ----
// Two independent array blocks with read port and command driven program and erase.
// Assumes a bus master that keeps the command discipline; one clock, inputs synchronous.
//
// Contract
// RQ1: Two independent 64k byte blocks, each 1024 rows of 64 bytes.
// RQ2: Erase sector is eight rows, 512 bytes; sector erase clears exactly that.
// RQ3: Reads of bytes, even address words and odd address words are supported.
// RQ4: Byte and aligned word reads take one cycle; odd words take two.
// RQ5: Only commands program or erase; no plain write path alters the array.
// RQ6: Sector erase and whole block mass erase are both supported.
// RQ7: Erased bits read one; programmed bits read zero.
// RQ8: Both blocks may program or erase at once, each with own state.
// RQ9: A busy block cannot be read; master waits until it finishes.
// RQ10: Master erases a word before programming it.
// RQ11: Master never programs one word twice without an erase between.
// RQ12: Master launches each operation with a three step sequence per block; the logic launches on one cmd_valid strobe.
// RQ13: Command registers sit at offsets 0x100 to 0x10F.
// RQ14: Sector erase ignores the low nine address bits of its address.
// RQ15: Per block busy holds from command launch until operation completes.
`timescale 1ns/10ps
`default_nettype none
`include "fba_cfg.svh"
module fba_top #(
  parameter int ROWS      = `FBA_ROWS,
  parameter int ROW_BYTES = `FBA_ROW_BYTES,
  parameter int SECT_ROWS = `FBA_SECT_ROWS
) (
  input  wire logic        clk_sys_i,
  input  wire logic        arst_n_i,
  input  wire logic        rd_req_i,
  input  wire logic [16:0] rd_addr_i,
  input  wire logic        rd_word_i,
  output logic             rd_ready_o,
  output logic             rd_valid_o,
  output logic             rd_err_o,
  output logic [15:0]      rd_data_o,
  input  wire logic        cmd_valid_i,
  input  wire logic [15:0] cmd_off_i,
  input  wire logic [1:0]  cmd_op_i,
  input  wire logic [16:0] cmd_addr_i,
  input  wire logic [15:0] cmd_data_i,
  output logic             cmd_ack_o,
  output logic             cmd_err_o,
  output logic [1:0]       busy_o
);
  localparam int WORDS = ROWS * ROW_BYTES / 2; // RQ1
  localparam int AW    = $clog2(WORDS);
  localparam int SW    = $clog2(SECT_ROWS * ROW_BYTES / 2); // RQ2

  // ************************************************************
  // Reset release
  // ************************************************************
  // Two stage release so every flop leaves reset on the same edge.
  logic rst_meta_r;
  logic rst_n_r;
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // ************************************************************
  // Command decode
  // ************************************************************
  logic          cmd_in_win;
  logic          cmd_op_ok;
  logic          cmd_blk;
  logic [1:0]    launch_w;
  logic [1:0]    busy_w;
  logic [AW-1:0] wptr_w [2];
  logic [15:0]   wdat_w [2];
  logic [1:0]    wen_w;
  logic [1:0]    wprog_w;
  logic          cmd_ack_nxt;
  logic          cmd_err_nxt;
  logic          cmd_ack_r;
  logic          cmd_err_r;

  // A command is only seen inside the register window; array writes do not exist.
  always_comb
  begin
    cmd_in_win  = (cmd_off_i >= `FBA_CMD_WIN_LO) && (cmd_off_i <= `FBA_CMD_WIN_HI); // RQ13
    cmd_op_ok   = (cmd_op_i == `FBA_OP_PROG) || (cmd_op_i == `FBA_OP_SECT) ||
                  (cmd_op_i == `FBA_OP_MASS);
    cmd_blk     = cmd_addr_i[16];
    launch_w    = 2'h0;
    cmd_ack_nxt = 1'b0;
    cmd_err_nxt = 1'b0;
    if (cmd_valid_i && cmd_in_win)
    begin
      if (cmd_op_ok && !busy_w[cmd_blk])
      begin
        launch_w[cmd_blk] = 1'b1; // RQ5
        cmd_ack_nxt       = 1'b1;
      end
      else
      begin
        cmd_err_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      cmd_ack_r <= 1'b0;
      cmd_err_r <= 1'b0;
    end
    else
    begin
      cmd_ack_r <= cmd_ack_nxt;
      cmd_err_r <= cmd_err_nxt;
    end
  end
  assign cmd_ack_o = cmd_ack_r;
  assign cmd_err_o = cmd_err_r;

  // ************************************************************
  // Per block operation engines
  // ************************************************************
  // Each block owns its own engine, so both may work at the same time.
  for (genvar g = 0; g < `FBA_BLOCKS; g++) // RQ8
  begin : g_blk
    fba_pkg::fba_blk_st_t st_r;
    fba_pkg::fba_blk_st_t st_nxt;
    logic [AW-1:0]        ptr_r;
    logic [AW-1:0]        ptr_nxt;
    logic [AW-1:0]        last_r;
    logic [AW-1:0]        last_nxt;
    logic [15:0]          data_r;
    logic [15:0]          data_nxt;
    logic                 busy_r;

    always_comb
    begin
      st_nxt   = st_r;
      ptr_nxt  = ptr_r;
      last_nxt = last_r;
      data_nxt = data_r;
      unique case (st_r)
        fba_pkg::BLK_IDLE:
        begin
          if (launch_w[g])
          begin
            data_nxt = cmd_data_i;
            if (cmd_op_i == `FBA_OP_PROG)
            begin
              st_nxt  = fba_pkg::BLK_PROG;
              ptr_nxt = cmd_addr_i[AW:1];
            end
            else if (cmd_op_i == `FBA_OP_SECT)
            begin
              st_nxt   = fba_pkg::BLK_ERASE; // RQ6
              ptr_nxt  = {cmd_addr_i[AW:SW+1], {SW{1'b0}}}; // RQ14
              last_nxt = {cmd_addr_i[AW:SW+1], {SW{1'b1}}}; // RQ2
            end
            else
            begin
              st_nxt   = fba_pkg::BLK_ERASE; // RQ6
              ptr_nxt  = '0;
              last_nxt = '1;
            end
          end
        end
        fba_pkg::BLK_PROG:
        begin
          st_nxt = fba_pkg::BLK_IDLE;
        end
        fba_pkg::BLK_ERASE:
        begin
          ptr_nxt = ptr_r + 1'b1;
          if (ptr_r == last_r)
          begin
            st_nxt = fba_pkg::BLK_IDLE;
          end
        end
      endcase
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_r)
    begin
      if (!rst_n_r)
      begin
        st_r   <= fba_pkg::BLK_IDLE;
        ptr_r  <= '0;
        last_r <= '0;
        data_r <= `FBA_ERASED_WORD;
        busy_r <= 1'b0;
      end
      else
      begin
        st_r   <= st_nxt;
        ptr_r  <= ptr_nxt;
        last_r <= last_nxt;
        data_r <= data_nxt;
        busy_r <= (st_nxt != fba_pkg::BLK_IDLE); // RQ15
      end
    end

    // Programming can only pull bits to zero; erase restores ones.
    assign busy_w[g] = busy_r;
    assign wen_w[g]  = (st_r != fba_pkg::BLK_IDLE);
    assign wprog_w[g] = (st_r == fba_pkg::BLK_PROG);
    assign wptr_w[g] = ptr_r;
    assign wdat_w[g] = (st_r == fba_pkg::BLK_PROG) ? data_r : `FBA_ERASED_WORD; // RQ7

    a_erase_start: assert property (@(posedge clk_sys_i) disable iff (!rst_n_r) // RQ14
      launch_w[g] && cmd_op_i == `FBA_OP_SECT |=> ptr_r[SW-1:0] == '0 && last_r[SW-1:0] == '1)
      else $error("sector erase does not span an aligned sector");
    a_mass_span: assert property (@(posedge clk_sys_i) disable iff (!rst_n_r) // RQ6
      launch_w[g] && cmd_op_i == `FBA_OP_MASS |=> ptr_r == '0 && last_r == '1)
      else $error("mass erase does not cover the whole block");
    a_erase_ones: assert property (@(posedge clk_sys_i) disable iff (!rst_n_r) // RQ7
      st_r == fba_pkg::BLK_ERASE |-> wen_w[g] && wdat_w[g] == `FBA_ERASED_WORD)
      else $error("erase writes a value other than all ones");
  end

  assign busy_o = busy_w;

  // ************************************************************
  // Array storage
  // ************************************************************
  // Storage has no reset; contents are undefined until erased.
  logic [15:0] mem [2][WORDS];
  always_ff @(posedge clk_sys_i)
  begin
    for (int b = 0; b < 2; b++)
    begin
      // Program only pulls bits low; erase writes ones over whatever was there.
      if (wen_w[b] && wprog_w[b])
      begin
        mem[b][wptr_w[b]] <= mem[b][wptr_w[b]] & wdat_w[b]; // RQ7
      end
      else if (wen_w[b])
      begin
        mem[b][wptr_w[b]] <= wdat_w[b]; // RQ7
      end
    end
  end

  // ************************************************************
  // Read port
  // ************************************************************
  fba_pkg::fba_rd_st_t rd_st_r;
  fba_pkg::fba_rd_st_t rd_st_nxt;
  logic          rd_blk_r;
  logic          rd_blk_nxt;
  logic [AW-1:0] rd_ptr_r;
  logic [AW-1:0] rd_ptr_nxt;
  logic [7:0]    rd_hold_r;
  logic [7:0]    rd_hold_nxt;
  logic          rd_valid_r;
  logic          rd_valid_nxt;
  logic          rd_err_r;
  logic          rd_err_nxt;
  logic [15:0]   rd_data_r;
  logic [15:0]   rd_data_nxt;
  logic [15:0]   rd_cur;

  // Even address bytes are the upper half of a word; an odd word needs two fetches.
  always_comb
  begin
    rd_st_nxt    = rd_st_r;
    rd_blk_nxt   = rd_blk_r;
    rd_ptr_nxt   = rd_ptr_r;
    rd_hold_nxt  = rd_hold_r;
    rd_valid_nxt = 1'b0;
    rd_err_nxt   = 1'b0;
    rd_data_nxt  = rd_data_r;
    rd_cur       = mem[rd_addr_i[16]][rd_addr_i[AW:1]];
    unique case (rd_st_r)
      fba_pkg::RD_IDLE:
      begin
        if (rd_req_i)
        begin
          if (busy_w[rd_addr_i[16]])
          begin
            rd_err_nxt = 1'b1; // RQ9
          end
          else if (!rd_word_i)
          begin
            rd_valid_nxt = 1'b1; // RQ4
            rd_data_nxt  = {8'h00, rd_addr_i[0] ? rd_cur[7:0] : rd_cur[15:8]}; // RQ3
          end
          else if (!rd_addr_i[0])
          begin
            rd_valid_nxt = 1'b1; // RQ4
            rd_data_nxt  = rd_cur; // RQ3
          end
          else
          begin
            rd_st_nxt   = fba_pkg::RD_SECOND; // RQ4
            rd_blk_nxt  = rd_addr_i[16];
            rd_ptr_nxt  = rd_addr_i[AW:1] + 1'b1;
            rd_hold_nxt = rd_cur[7:0];
          end
        end
      end
      fba_pkg::RD_SECOND:
      begin
        rd_st_nxt    = fba_pkg::RD_IDLE;
        rd_valid_nxt = 1'b1;
        rd_data_nxt  = {rd_hold_r, mem[rd_blk_r][rd_ptr_r][15:8]}; // RQ3
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      rd_st_r    <= fba_pkg::RD_IDLE;
      rd_blk_r   <= 1'b0;
      rd_ptr_r   <= '0;
      rd_hold_r  <= 8'h00;
      rd_valid_r <= 1'b0;
      rd_err_r   <= 1'b0;
      rd_data_r  <= 16'h0000;
      rd_ready_o <= 1'b0;
    end
    else
    begin
      rd_st_r    <= rd_st_nxt;
      rd_blk_r   <= rd_blk_nxt;
      rd_ptr_r   <= rd_ptr_nxt;
      rd_hold_r  <= rd_hold_nxt;
      rd_valid_r <= rd_valid_nxt;
      rd_err_r   <= rd_err_nxt;
      rd_data_r  <= rd_data_nxt;
      rd_ready_o <= (rd_st_nxt == fba_pkg::RD_IDLE);
    end
  end
  assign rd_valid_o = rd_valid_r;
  assign rd_err_o   = rd_err_r;
  assign rd_data_o  = rd_data_r;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_r);

  sequence s_odd_req;
    rd_ready_o && rd_req_i && rd_word_i && rd_addr_i[0] && !busy_w[rd_addr_i[16]];
  endsequence
  sequence s_two_step;
    !rd_valid_o ##1 rd_valid_o;
  endsequence

  a_rd_one_cycle: assert property (rd_ready_o && rd_req_i && !busy_w[rd_addr_i[16]] && // RQ4
    !(rd_word_i && rd_addr_i[0]) |=> rd_valid_o)
    else $error("single cycle read did not answer next cycle");
  a_rd_odd_word: assert property (s_odd_req |=> s_two_step) // RQ4
    else $error("odd word read did not take two cycles");
  a_rd_busy_err: assert property (rd_ready_o && rd_req_i && busy_w[rd_addr_i[16]] // RQ9
    |=> rd_err_o && !rd_valid_o)
    else $error("read of a busy block was answered with data");
  a_byte_zero: assert property ($rose(rd_valid_o) && $past(rd_ready_o) // RQ3
    && !$past(rd_word_i) |-> rd_data_o[15:8] == 8'h00)
    else $error("byte read upper half not zero");
  a_busy_launch: assert property (launch_w[0] |=> busy_o[0]) // RQ15
    else $error("block did not turn busy after launch");
  a_blk_indep: assert property (launch_w[0] && !launch_w[1] && !busy_w[1] |=> !busy_o[1]) // RQ8
    else $error("launch on one block disturbed the other");
  a_cmd_window: assert property (cmd_valid_i && !cmd_in_win |=> !cmd_ack_o && !cmd_err_o) // RQ13
    else $error("command outside the register window was taken");
  // Looks at the stored cell, so a block 0 erase that leaves old bits behind is caught.
  a_erase_cell: assert property (wen_w[0] && !wprog_w[0] // RQ7
    |=> mem[0][$past(wptr_w[0])] == `FBA_ERASED_WORD)
    else $error("erased cell does not read all ones");
endmodule
`default_nettype wire

// ---- tb/fba_cpu_model.sv ----
// Bus master model that drives the read port and the command strobe of the array.
// Assumes one clock and a design that registers every answer it gives.
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Bus master model
// ****************************************************************
module fba_cpu_model (
  input  wire logic        clk_sys_i,
  input  wire logic        rd_ready_i,
  input  wire logic        rd_valid_i,
  input  wire logic        rd_err_i,
  input  wire logic [15:0] rd_data_i,
  input  wire logic        cmd_ack_i,
  input  wire logic        cmd_err_i,
  input  wire logic [1:0]  busy_i,
  output logic             rd_req_o,
  output logic [16:0]      rd_addr_o,
  output logic             rd_word_o,
  output logic             cmd_valid_o,
  output logic [15:0]      cmd_off_o,
  output logic [1:0]       cmd_op_o,
  output logic [16:0]      cmd_addr_o,
  output logic [15:0]      cmd_data_o
);
  // Every input of the design has a value at time zero.
  initial
  begin
    rd_req_o    = 1'b0;
    rd_addr_o   = 17'h00000;
    rd_word_o   = 1'b0;
    cmd_valid_o = 1'b0;
    cmd_off_o   = 16'h0000;
    cmd_op_o    = 2'h0;
    cmd_addr_o  = 17'h00000;
    cmd_data_o  = 16'h0000;
  end

  // One strobe carries the whole launch; stored data only changes this way.
  task automatic cmd(input logic [15:0] off, input logic [1:0] op, input logic [16:0] addr,
                     input logic [15:0] data, output logic ack, output logic err);
    @(posedge clk_sys_i);
    cmd_valid_o <= 1'b1;
    cmd_off_o   <= off;
    cmd_op_o    <= op;
    cmd_addr_o  <= addr;
    cmd_data_o  <= data;
    @(posedge clk_sys_i);
    cmd_valid_o <= 1'b0;
    cmd_addr_o  <= ~addr; // Released address and data lines show junk, never the last value.
    cmd_data_o  <= ~data;
    #1;
    ack = cmd_ack_i;
    err = cmd_err_i;
  endtask

  // Waits for the port to accept, then returns data, refusal and latency in cycles.
  task automatic rd(input logic [16:0] addr, input logic word, output logic [15:0] data,
                    output logic err, output int lat);
    int n;
    n = 0;
    while (rd_ready_i !== 1'b1 && n < 50)
    begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    @(posedge clk_sys_i);
    rd_req_o  <= 1'b1;
    rd_addr_o <= addr;
    rd_word_o <= word;
    @(posedge clk_sys_i);
    rd_req_o  <= 1'b0;
    rd_addr_o <= ~addr;
    for (lat = 1; lat <= 4; lat++)
    begin
      #1;
      if (rd_valid_i === 1'b1 || rd_err_i === 1'b1)
        break;
      @(posedge clk_sys_i);
    end
    data = rd_data_i;
    err  = rd_err_i;
  endtask

  // The master holds off a block until its busy level drops, counting busy cycles.
  task automatic wait_idle(input int b, output int cyc);
    cyc = 0;
    while (busy_i[b] === 1'b1 && cyc < 40000)
    begin
      @(posedge clk_sys_i);
      #1;
      cyc++;
    end
  endtask
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for the dual block array with shortened blocks.
// Assumes the bus master model drives all inputs except the clock and the reset.
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Testbench top
// ****************************************************************
module tb_top;
  logic        clk_sys = 1'b0;
  logic        arst_n  = 1'b0;
  int          error_cnt = 0;
  int          samples_checked = 0;
  wire         rd_req, rd_word, rd_ready, rd_valid, rd_err, cmd_valid, cmd_ack, cmd_err;
  wire  [16:0] rd_addr, cmd_addr;
  wire  [15:0] rd_data, cmd_off, cmd_data;
  wire  [1:0]  cmd_op, busy;

  // Sixteen rows per block keep a mass erase short.
  fba_top #(.ROWS(16)) fba_top_i (.clk_sys_i(clk_sys), .arst_n_i(arst_n),
    .rd_req_i(rd_req), .rd_addr_i(rd_addr), .rd_word_i(rd_word), .rd_ready_o(rd_ready),
    .rd_valid_o(rd_valid), .rd_err_o(rd_err), .rd_data_o(rd_data), .cmd_valid_i(cmd_valid),
    .cmd_off_i(cmd_off), .cmd_op_i(cmd_op), .cmd_addr_i(cmd_addr), .cmd_data_i(cmd_data),
    .cmd_ack_o(cmd_ack), .cmd_err_o(cmd_err), .busy_o(busy));
  fba_cpu_model fba_cpu_model_i (.clk_sys_i(clk_sys), .rd_ready_i(rd_ready),
    .rd_valid_i(rd_valid), .rd_err_i(rd_err), .rd_data_i(rd_data), .cmd_ack_i(cmd_ack),
    .cmd_err_i(cmd_err), .busy_i(busy), .rd_req_o(rd_req), .rd_addr_o(rd_addr),
    .rd_word_o(rd_word), .cmd_valid_o(cmd_valid), .cmd_off_o(cmd_off), .cmd_op_o(cmd_op),
    .cmd_addr_o(cmd_addr), .cmd_data_o(cmd_data));

  // A 4 ns clock.
  always #2 clk_sys = ~clk_sys;

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      error_cnt++;
    end
  endtask

  task automatic report_and_stop;
    if (error_cnt == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Erase the whole block, program two words, then erase the next sector only.
  task automatic t_sector;
    logic a, e;
    logic [15:0] d;
    int n;
    fba_cpu_model_i.cmd(16'h0100, 2'h3, 17'h00000, 16'h0000, a, e);
    check(16'(a), 16'h0001);
    fba_cpu_model_i.wait_idle(0, n);
    fba_cpu_model_i.cmd(16'h0104, 2'h1, 17'h001FE, 16'h1234, a, e);
    fba_cpu_model_i.wait_idle(0, n);
    check(16'(n), 16'h0001);
    fba_cpu_model_i.cmd(16'h0106, 2'h1, 17'h00200, 16'h0F0F, a, e);
    fba_cpu_model_i.wait_idle(0, n);
    fba_cpu_model_i.cmd(16'h010F, 2'h2, 17'h00234, 16'h0000, a, e);
    fba_cpu_model_i.wait_idle(0, n);
    check(16'(n), 16'h0100);
    fba_cpu_model_i.rd(17'h001FE, 1'b1, d, e, n);
    check(d, 16'h1234);
    fba_cpu_model_i.rd(17'h00200, 1'b1, d, e, n);
    check(d, 16'hFFFF);
    fba_cpu_model_i.rd(17'h003FE, 1'b1, d, e, n);
    check(d, 16'hFFFF);
  endtask

  // Byte, even word and odd word reads with their latencies.
  task automatic t_reads;
    logic a, e;
    logic [15:0] d;
    int n;
    fba_cpu_model_i.cmd(16'h0108, 2'h1, 17'h00200, 16'hA55A, a, e);
    fba_cpu_model_i.wait_idle(0, n);
    fba_cpu_model_i.rd(17'h00200, 1'b1, d, e, n);
    check(d, 16'hA55A);
    check(16'(n), 16'h0001);
    fba_cpu_model_i.rd(17'h00200, 1'b0, d, e, n);
    check(d, 16'h00A5);
    fba_cpu_model_i.rd(17'h00201, 1'b0, d, e, n);
    check(d, 16'h005A);
    check(16'(n), 16'h0001);
    fba_cpu_model_i.rd(17'h001FF, 1'b1, d, e, n);
    check(d, 16'h34A5);
    check(16'(n), 16'h0002);
    check(16'(rd_ready), 16'h0001);
  endtask

  // Writes outside the command window and unknown codes must not touch the array.
  task automatic t_refuse;
    logic a, e;
    logic [15:0] d;
    int n;
    fba_cpu_model_i.cmd(16'h00FF, 2'h1, 17'h00200, 16'h0000, a, e);
    check(16'({a, e}), 16'h0000);
    fba_cpu_model_i.cmd(16'h0110, 2'h3, 17'h00000, 16'h0000, a, e);
    check(16'({busy, a, e}), 16'h0000);
    fba_cpu_model_i.cmd(16'h0102, 2'h0, 17'h00200, 16'h0000, a, e);
    check(16'({a, e}), 16'h0001);
    fba_cpu_model_i.rd(17'h00200, 1'b1, d, e, n);
    check(d, 16'hA55A);
  endtask

  // Both blocks busy at once; a busy block refuses reads and a second command.
  task automatic t_concurrent;
    logic a, e;
    logic [15:0] d;
    int n;
    fba_cpu_model_i.cmd(16'h0100, 2'h2, 17'h00000, 16'h0000, a, e);
    check(16'({busy, a}), 16'h0003);
    fba_cpu_model_i.rd(17'h001FE, 1'b1, d, e, n);
    check(16'(e), 16'h0001);
    fba_cpu_model_i.cmd(16'h0100, 2'h3, 17'h10000, 16'h0000, a, e);
    check(16'({busy, a}), 16'h0007);
    fba_cpu_model_i.cmd(16'h0100, 2'h2, 17'h00000, 16'h0000, a, e);
    check(16'({a, e}), 16'h0001);
    fba_cpu_model_i.rd(17'h10000, 1'b0, d, e, n);
    check(16'(e), 16'h0001);
    fba_cpu_model_i.wait_idle(0, n);
    fba_cpu_model_i.wait_idle(1, n);
    fba_cpu_model_i.rd(17'h103FE, 1'b1, d, e, n);
    check(d, 16'hFFFF);
    fba_cpu_model_i.rd(17'h001FE, 1'b1, d, e, n);
    check(d, 16'hFFFF);
    fba_cpu_model_i.rd(17'h00200, 1'b1, d, e, n);
    check(d, 16'hA55A);
  endtask

  // A reset in mid erase clears busy at once; stored words are not reset.
  task automatic t_reset;
    logic a, e;
    logic [15:0] d;
    int n;
    fba_cpu_model_i.cmd(16'h0100, 2'h3, 17'h10000, 16'h0000, a, e);
    @(posedge clk_sys);
    arst_n <= 1'b0;
    #1;
    check(16'({busy, rd_ready, cmd_ack}), 16'h0000);
    @(posedge clk_sys);
    arst_n <= 1'b1;
    fba_cpu_model_i.rd(17'h10000, 1'b0, d, e, n);
    check(16'(e), 16'h0000);
    check(d, 16'h00FF);
  endtask

  // Main sequence: reset for four cycles, let the port come up, then the scenarios.
  initial
  begin
    repeat (4) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    t_sector();
    t_reads();
    t_refuse();
    t_concurrent();
    t_reset();
    report_and_stop();
  end

  // The scenarios need some 1350 cycles; about eighteen times that means a hang.
  initial
  begin
    #100000;
    error_cnt++;
    report_and_stop();
  end
endmodule
`default_nettype wire
